// >>> src/addr_map_pkg.sv
// Package: address map constants, bus mode and decode carriers.
// Assumes a 16-bit address space with banked lower half.
package addr_map_pkg;

  localparam int ADDR_W = 16;          // CPU address width
  localparam int BANK_W = 4;           // Bank-select lines
  localparam int PHYS_W = ADDR_W + BANK_W - 1; // 19-bit physical address

  localparam logic [ADDR_W-1:0] ONCHIP_LAST = 16'h01FF; // On-chip top
  localparam logic [ADDR_W-1:0] EXT_FIRST = 16'h0200;   // External start
  localparam logic [ADDR_W-1:0] LOW_PAGE_LAST = 16'h00FF; // Direct page top
  localparam logic [ADDR_W-1:0] USER_RAM_LAST = 16'h00BF; // User RAM top
  localparam logic [ADDR_W-1:0] BANKED_LAST = 16'h7FFF;   // Banked top
  localparam int UPPER_BIT = 15;       // Set for common upper half

  // Decode target of an access
  typedef enum logic [1:0] {
    TGT_NONE = 2'b00,
    TGT_ONCHIP = 2'b01,
    TGT_EXTERNAL = 2'b10
  } target_t;

  // External bus width mode
  typedef enum logic {
    BUS_16 = 1'b0,
    BUS_8 = 1'b1
  } bus_mode_t;

  // CPU access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } cpu_req_t;

  // Decoded result
  typedef struct packed {
    target_t target;
    logic low_page;
    logic user_ram;
    logic pointer_ok;
    logic [PHYS_W-1:0] phys;
  } decode_t;

endpackage

// >>> src/address_decode_bank_switch.sv
// Address decoder and bank switch for a 64 kbyte space.
// Assumes CPU request on ref_clk; bank lines and byte-enable strap from pins.
// Contract
// R1 - Addresses up to 0x1FF reach on-chip resources
// R2 - Low page 0-0xFF, user RAM 0-0xBF
// R3 - User RAM words usable as indirect pointers
// R4 - Addresses from 0x200 go external
// R5 - Four lines pick one of sixteen banks
// R6 - Upper half ignores bank select
// R7 - On-chip region ignores bank select
// R8 - Strap at reset picks 8 or 16-bit bus
// R9 - Bank bits drive high address, held per cycle
`timescale 1ns/1ns
module address_decode_bank_switch (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire addr_map_pkg::cpu_req_t cpu_req,
  input wire logic cpu_cycle_end,
  input wire logic [addr_map_pkg::BANK_W-1:0] bank_pins,
  input wire logic high_byte_en_in,
  input wire logic high_byte_en_driven,
  output addr_map_pkg::decode_t decode,
  output logic ext_active,
  output addr_map_pkg::bus_mode_t bus_mode
);
  import addr_map_pkg::*;

  // First physical bit above the on-chip region; all zero for on-chip hits
  localparam int ONCHIP_TOP_BIT = $clog2(int'(ONCHIP_LAST) + 1);

  // Pin synchronisers, two stages each; no reset, so a strap held
  // through reset is already in the second stage when reset lifts
  logic [BANK_W-1:0] bank_s1, bank_s2;
  logic [1:0] hbe_s1, hbe_s2;
  // Strap capture happens once, on the first edge out of reset
  logic strap_done, next_strap_done;
  bus_mode_t next_bus_mode;
  // Bank latched for the whole bus cycle
  logic [BANK_W-1:0] held_bank, next_held_bank;
  logic next_ext_active;
  decode_t next_decode;

  // Classify an address
  function automatic target_t classify(input logic [ADDR_W-1:0] a);
    if (a <= ONCHIP_LAST) begin
      classify = TGT_ONCHIP; // R1
    end else begin
      classify = TGT_EXTERNAL; // R4
    end
  endfunction

  // Synchroniser registers, free running through reset
  // Only the second stage is read; the first may be metastable
  always_ff @(posedge ref_clk) begin
    bank_s1 <= bank_pins;
    bank_s2 <= bank_s1;
    hbe_s1 <= {high_byte_en_driven, high_byte_en_in};
    hbe_s2 <= hbe_s1;
  end

  // Strap decision: high and driven means 8-bit, else floating means 16-bit
  always_comb begin
    next_strap_done = strap_done;
    next_bus_mode = bus_mode;
    if (!strap_done) begin
      next_strap_done = 1'b1;
      if (hbe_s2[1] && hbe_s2[0]) begin
        next_bus_mode = BUS_8; // R8
      end else begin
        next_bus_mode = BUS_16; // R8
      end
    end
  end

  // Strap registers; reset holds capture open
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      strap_done <= 1'b0;
      bus_mode <= BUS_16;
    end else begin
      strap_done <= next_strap_done;
      bus_mode <= next_bus_mode;
    end
  end

  // Decode and bank hold
  always_comb begin
    next_held_bank = held_bank;
    next_ext_active = ext_active;
    next_decode = '0;
    // Closing pulse first, so an external request in the same cycle wins below
    if (cpu_cycle_end) begin
      next_ext_active = 1'b0; // R9
    end
    // Bank sampled only at cycle start so it cannot change mid-cycle;
    // a closing cycle frees the hold for a request riding on it
    if (cpu_req.valid && (!ext_active || cpu_cycle_end)) begin
      next_held_bank = bank_s2; // R9
    end
    if (cpu_req.valid) begin
      next_decode.target = classify(cpu_req.addr);
      next_decode.low_page = cpu_req.addr <= LOW_PAGE_LAST; // R2
      next_decode.user_ram = cpu_req.addr <= USER_RAM_LAST; // R2
      next_decode.pointer_ok = cpu_req.addr <= USER_RAM_LAST; // R3
      if (next_decode.target == TGT_ONCHIP) begin
        // No bank bits, same cells in every bank
        next_decode.phys = {{(BANK_W-1){1'b0}}, cpu_req.addr}; // R7
      end else if (cpu_req.addr[UPPER_BIT]) begin
        // Common half maps onto the bank 15 range
        next_decode.phys = {{(BANK_W-1){1'b1}}, cpu_req.addr}; // R6
      end else begin
        next_decode.phys = {next_held_bank,
                            cpu_req.addr[UPPER_BIT-1:0]}; // R5
      end
      if (next_decode.target == TGT_EXTERNAL) begin
        // Opening an external cycle beats a close in the same cycle
        next_ext_active = 1'b1; // R4
      end
    end
  end

  // Decode registers
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      held_bank <= '0;
      ext_active <= 1'b0;
      decode <= '0;
    end else begin
      held_bank <= next_held_bank;
      ext_active <= next_ext_active;
      decode <= next_decode;
    end
  end

  // Checks. Each registered output is judged one edge after the request
  // that made it; the disable keeps them quiet across a mid-run reset.

  // Low addresses land on chip
  chk_onchip_route: assert property ( // R1
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_req.valid && cpu_req.addr <= ONCHIP_LAST |=>
    decode.target == TGT_ONCHIP)
    else $error("on-chip misrouted");

  // Direct page flag tracks the address
  chk_low_page: assert property ( // R2
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_req.valid |=>
    decode.low_page == ($past(cpu_req.addr) <= LOW_PAGE_LAST))
    else $error("low page wrong");

  // User RAM flag tracks the address
  chk_user_ram: assert property ( // R2
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_req.valid |=>
    decode.user_ram == ($past(cpu_req.addr) <= USER_RAM_LAST))
    else $error("user ram wrong");

  // Pointer words only inside user RAM of the direct page
  chk_pointer_ram: assert property ( // R3
    @(posedge ref_clk) disable iff (!reset_n)
    decode.pointer_ok |-> decode.user_ram && decode.low_page)
    else $error("pointer outside ram");

  // Every user RAM word may serve as a pointer
  chk_pointer_all: assert property ( // R3
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_req.valid && cpu_req.addr <= USER_RAM_LAST |=> decode.pointer_ok)
    else $error("pointer refused");

  // Everything from the external start goes off chip and opens a cycle
  chk_ext_route: assert property ( // R4
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_req.valid && cpu_req.addr >= EXT_FIRST |=>
    decode.target == TGT_EXTERNAL && ext_active)
    else $error("external misrouted");

  // No request, no target: memory must not see a phantom access
  chk_idle_quiet: assert property ( // R4
    @(posedge ref_clk) disable iff (!reset_n)
    !cpu_req.valid |=> decode == '0)
    else $error("decode without request");

  // Banked external request, lower half above the on-chip region
  sequence s_banked_req;
    cpu_req.valid && cpu_req.addr >= EXT_FIRST && !cpu_req.addr[UPPER_BIT];
  endsequence

  // Held bank on top, address offset below
  chk_bank_bits: assert property ( // R5
    @(posedge ref_clk) disable iff (!reset_n)
    s_banked_req |=>
    decode.phys[PHYS_W-1:UPPER_BIT] == held_bank &&
    decode.phys[UPPER_BIT-1:0] == $past(cpu_req.addr[UPPER_BIT-1:0]))
    else $error("bank bits wrong");

  // Cycle start: the synchronised port value is what gets held
  sequence s_cycle_start;
    cpu_req.valid && (!ext_active || cpu_cycle_end);
  endsequence

  chk_bank_take: assert property ( // R5
    @(posedge ref_clk) disable iff (!reset_n)
    s_cycle_start |=> held_bank == $past(bank_s2))
    else $error("bank not taken");

  // Common half carries an all-ones bank field and the full offset
  chk_upper_common: assert property ( // R6
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_req.valid && cpu_req.addr[UPPER_BIT] |=>
    &decode.phys[PHYS_W-1:UPPER_BIT] &&
    decode.phys[UPPER_BIT-1:0] == $past(cpu_req.addr[UPPER_BIT-1:0]))
    else $error("upper not common");

  // On-chip hits never carry bank bits
  chk_onchip_flat: assert property ( // R7
    @(posedge ref_clk) disable iff (!reset_n)
    decode.target == TGT_ONCHIP |->
    decode.phys[PHYS_W-1:ONCHIP_TOP_BIT] == '0)
    else $error("on-chip banked");

  // On-chip physical address is the CPU address itself
  chk_onchip_addr: assert property ( // R7
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_req.valid && cpu_req.addr <= ONCHIP_LAST |=>
    decode.phys == PHYS_W'($past(cpu_req.addr)))
    else $error("on-chip address moved");

  // Strap taken from the second stage on the first edge out of reset
  chk_strap_take: assert property ( // R8
    @(posedge ref_clk) disable iff (!reset_n)
    $rose(strap_done) |->
    bus_mode == ($past(hbe_s2[1] && hbe_s2[0]) ? BUS_8 : BUS_16))
    else $error("strap misread");

  // Mode frozen once taken
  chk_strap_hold: assert property ( // R8
    @(posedge ref_clk) disable iff (!reset_n)
    strap_done |=> $stable(bus_mode))
    else $error("bus mode moved");

  // An open bus cycle keeps its bank lines still
  sequence s_ext_open;
    ext_active && !cpu_cycle_end;
  endsequence

  chk_bank_stable: assert property ( // R9
    @(posedge ref_clk) disable iff (!reset_n)
    s_ext_open |=> $stable(held_bank))
    else $error("bank moved");

  // A close with no new external request ends the cycle
  chk_cycle_close: assert property ( // R9
    @(posedge ref_clk) disable iff (!reset_n)
    cpu_cycle_end && !(cpu_req.valid && cpu_req.addr >= EXT_FIRST) |=>
    !ext_active)
    else $error("cycle not closed");

endmodule // address_decode_bank_switch

// >>> testbench/ext_mem_model.sv
// External memory model: notes the physical address of each external access.
// Assumes the decode carrier comes from the decoder on the same clock.
`timescale 1ns/1ns
module ext_mem_model (
  input wire logic ref_clk,
  input wire addr_map_pkg::decode_t decode,
  output logic [addr_map_pkg::PHYS_W-1:0] seen_phys
);
  import addr_map_pkg::*;
  // Latch the address of each external access
  always_ff @(posedge ref_clk) begin
    if (decode.target == TGT_EXTERNAL) seen_phys <= decode.phys;
  end
endmodule // ext_mem_model

// >>> testbench/address_decode_bank_switch_tb_top.sv
// Testbench for the address decoder and bank switch.
// Assumes the package and the memory model are compiled first.
`timescale 1ns/1ns
`define CHK(n, e, s) begin total_checks++; if ((s) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", n, e, s); end end
module address_decode_bank_switch_tb_top;
  import addr_map_pkg::*;
  logic ref_clk = 0, reset_n = 0, cpu_cycle_end = 0;
  logic high_byte_en_in = 1, high_byte_en_driven = 1;
  logic [BANK_W-1:0] bank_pins = 4'h5;
  cpu_req_t cpu_req = '0;
  decode_t decode;
  logic ext_active;
  bus_mode_t bus_mode;
  logic [PHYS_W-1:0] seen_phys;
  int n_errors = 0, total_checks = 0, cyc = 0;
  address_decode_bank_switch i_dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .cpu_req(cpu_req), .cpu_cycle_end(cpu_cycle_end),
    .bank_pins(bank_pins), .high_byte_en_in(high_byte_en_in),
    .high_byte_en_driven(high_byte_en_driven), .decode(decode),
    .ext_active(ext_active), .bus_mode(bus_mode));
  ext_mem_model i_mem (.ref_clk(ref_clk), .decode(decode),
    .seen_phys(seen_phys));
  initial forever #4 ref_clk = ~ref_clk;
  // Hang guard, about thirteen times the few hundred cycles needed
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end
  task automatic conclude();
    if (n_errors == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Reset with the strap held steady through the sync stages
  task automatic do_reset(input logic drv, input bus_mode_t m);
    @(posedge ref_clk);
    #1 reset_n = 0;
    high_byte_en_driven = drv;
    repeat (6) @(posedge ref_clk);
    #1 reset_n = 1;
    repeat (3) @(posedge ref_clk);
    #1 `CHK("bus_mode", m, bus_mode)
  endtask
  // One-cycle request, decode judged a cycle later
  task automatic acc(input logic [15:0] a, input target_t t,
      input logic [2:0] f, input logic [PHYS_W-1:0] p);
    @(posedge ref_clk);
    #1 cpu_req = {1'b1, a[0], a};
    @(posedge ref_clk);
    #1 cpu_req = '0;
    `CHK("target", t, decode.target)
    `CHK("flags", f, {decode.low_page, decode.user_ram, decode.pointer_ok})
    `CHK("phys", p, decode.phys)
    `CHK("ext", t == TGT_EXTERNAL, ext_active)
  endtask
  // Close an external cycle and let the bank hold release
  task automatic end_cycle();
    cpu_cycle_end = 1;
    @(posedge ref_clk);
    #1 cpu_cycle_end = 0;
    repeat (2) @(posedge ref_clk);
    #1 `CHK("ext_end", 1'b0, ext_active)
  endtask
  // Pins pass a two-stage synchroniser, so settle three edges
  task automatic set_bank(input logic [BANK_W-1:0] b);
    bank_pins = b;
    repeat (3) @(posedge ref_clk);
  endtask
  // On-chip edges of the pages under four bank values
  task automatic t_onchip();
    for (int b = 0; b < 16; b += 5) begin
      set_bank(BANK_W'(b));
      acc(16'h0000, TGT_ONCHIP, 3'h7, 19'h00000);
      acc(16'h00BF, TGT_ONCHIP, 3'h7, 19'h000BF);
      acc(16'h00C0, TGT_ONCHIP, 3'h4, 19'h000C0);
      acc(16'h0100, TGT_ONCHIP, 3'h0, 19'h00100);
      acc(16'h01FF, TGT_ONCHIP, 3'h0, 19'h001FF);
    end
  endtask
  // Every bank for banked ends, plus the common upper half
  task automatic t_banks();
    for (int b = 0; b < 16; b++) begin
      set_bank(BANK_W'(b));
      acc(16'h0200, TGT_EXTERNAL, 3'h0, {BANK_W'(b), 15'h0200});
      end_cycle();
      `CHK("mem", {BANK_W'(b), 15'h0200}, seen_phys)
      acc(16'h7FFF, TGT_EXTERNAL, 3'h0, {BANK_W'(b), 15'h7FFF});
      end_cycle();
      acc(16'h8000, TGT_EXTERNAL, 3'h0, {3'h7, 16'h8000});
      end_cycle();
    end
  endtask
  // Bank change mid-cycle is held off until the cycle ends
  task automatic t_hold();
    set_bank(4'h3);
    acc(16'h1234, TGT_EXTERNAL, 3'h0, {4'h3, 15'h1234});
    set_bank(4'h9);
    acc(16'h1236, TGT_EXTERNAL, 3'h0, {4'h3, 15'h1236});
    end_cycle();
    acc(16'h1234, TGT_EXTERNAL, 3'h0, {4'h9, 15'h1234});
    end_cycle();
  endtask
  // Close and new external request on one edge: the new cycle wins and
  // takes the fresh bank; the close stays high straight into end_cycle
  task automatic t_turn();
    set_bank(4'h6);
    acc(16'h2000, TGT_EXTERNAL, 3'h0, {4'h6, 15'h2000});
    set_bank(4'hA);
    @(posedge ref_clk);
    #1 cpu_req = {1'b1, 1'b0, 16'h3000};
    cpu_cycle_end = 1;
    @(posedge ref_clk);
    #1 cpu_req = '0;
    `CHK("turn_phys", {4'hA, 15'h3000}, decode.phys)
    `CHK("turn_ext", 1'b1, ext_active)
    end_cycle();
  endtask
  initial begin
    do_reset(1'b1, BUS_8);
    t_onchip();
    t_banks();
    t_hold();
    t_turn();
    do_reset(1'b0, BUS_16);
    conclude();
  end
endmodule // address_decode_bank_switch_tb_top
